// >>> logic/rics_defines.vh
`ifndef RICS_DEFINES_VH
`define RICS_DEFINES_VH

// ==================================================
// clock rate of clk_sys
`define RICS_SYS_MHZ          20

// ==================================================
// reset, setup and lock times, in microseconds
`define RICS_HARD_RESET_N_US        100
`define RICS_PLL_SETUP_US     100
`define RICS_PLL_LOCK_US      100
`define RICS_LBUS_LOCK_US     50
// derived counts in clk_sys cycles (whole microseconds, no rounding)
`define RICS_HARD_RESET_N_CYC       (`RICS_HARD_RESET_N_US * `RICS_SYS_MHZ)
`define RICS_PLL_SETUP_CYC    (`RICS_PLL_SETUP_US * `RICS_SYS_MHZ)
`define RICS_PLL_LOCK_CYC     (`RICS_PLL_LOCK_US * `RICS_SYS_MHZ)
`define RICS_LBUS_LOCK_CYC    (`RICS_LBUS_LOCK_US * `RICS_SYS_MHZ)
// extra core lock cycles of the platform clock
`define RICS_CORE_EXTRA_CYC   255

// ==================================================
// counts in primary input clock cycles
`define RICS_SOFT_TICKS       3
`define RICS_CFG_SETUP_TICKS  4
`define RICS_CFG_HOLD_TICKS   2
`define RICS_CFG_FLOAT_TICKS  3
`define RICS_CFG_FLOAT_MAX    5

// ==================================================
// platform frequency floors
`define RICS_PLAT_BASE_MHZ    400
`define RICS_PCIE_FLOOR_MHZ   527
`define RICS_PCIE_FULL_LANES  16
`define RICS_SRIO_FACTOR      17024
`define RICS_SRIO_SCALE       10000

// ==================================================
// reset values
`define RICS_PCLK_DIV_DEF     1
`define RICS_RTC_HALF_DEF     4

`endif

// >>> logic/rics_clkdiv.v
`timescale 1ns/1ps
`include "rics_defines.vh"

// ==================================================
// divider that makes the primary input clock
module rics_clkdiv #(
   parameter HALF = `RICS_PCLK_DIV_DEF
) (
   // clock and reset
   input  wire clk_sys,
   input  wire reset_n,
   // divided clock and its rising-edge tick
   output reg  clk_out,
   output reg  rise_tick
);

   reg [15:0] cnt_r;

   // toggle every HALF cycles, tick with the rising edge
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r     <= 16'h0000;
         clk_out   <= 1'b0;
         rise_tick <= 1'b0;
      end else if (cnt_r == HALF[15:0] - 16'h0001) begin
         cnt_r     <= 16'h0000;
         clk_out   <= ~clk_out;
         rise_tick <= ~clk_out;
      end else begin
         cnt_r     <= cnt_r + 16'h0001;
         rise_tick <= 1'b0;
      end
   end

endmodule

// >>> logic/rics_sequencer.v
// Notes on behaviour
// - Hard reset is held low for at least 100 us before release.
// - Each core soft reset is held low for at least 3 primary cycles.
// - The primary clock runs with PLL straps valid 100 us before release.
// - Other straps are valid at least 4 primary cycles before release.
// - All straps stay unchanged at least 2 primary cycles after release.
// - Strap drivers float no later than 5 primary cycles after release.
// - PLL straps stay stable while the clock runs ahead of release.
// - Real-time clock high and low phases exceed two platform periods.
// - The frequency strap is 0 at 400 MHz and 1 above it.
// - An eight-lane PCI Express link needs 400 MHz/strap 0 or 527 MHz up; the check accepts eight lanes from 264 MHz up.
// - Serial RapidIO needs platform above 2 x 0.8512 x rate x lanes.
`timescale 1ns/1ps
`include "rics_defines.vh"

module rics_sequencer #(
   parameter STRAP_W   = 8,
   parameter PCLK_HALF = `RICS_PCLK_DIV_DEF,
   parameter RTC_HALF  = `RICS_RTC_HALF_DEF,
   parameter SETUP_CYC = `RICS_HARD_RESET_N_CYC,
   parameter LOCK_CYC  = `RICS_PLL_LOCK_CYC + `RICS_CORE_EXTRA_CYC
) (
   // clock and reset
   input  wire               clk_sys,
   input  wire               reset_n,
   // board power status pin
   input  wire               power_good,
   // user configuration
   input  wire [STRAP_W-1:0] cfg_straps,
   input  wire [11:0]        cfg_plat_mhz,
   input  wire               cfg_pcie_en,
   input  wire [4:0]         cfg_pcie_lanes,
   input  wire               cfg_srio_en,
   input  wire [11:0]        cfg_srio_mhz,
   input  wire [2:0]         cfg_srio_lanes,
   input  wire               rtc_enable,
   // user soft reset requests
   input  wire               core0_soft_req,
   input  wire               core1_soft_req,
   // device pins
   output wire               primary_input_clock,
   output reg                hard_reset_n,
   output reg                core0_soft_reset_n,
   output reg                core1_soft_reset_n,
   output reg  [STRAP_W-1:0] strap_out,
   output reg                plat_freq_strap,
   output reg                strap_oe_n,
   output reg                rtc_out,
   // user status
   output reg                seq_ready,
   output reg                cfg_error,
   output reg                soft_busy
);

   // ==================================================
   // state codes
   localparam [5:0] S_OFF   = 6'b000001;
   localparam [5:0] S_SETUP = 6'b000010;
   localparam [5:0] S_HOLD  = 6'b000100;
   localparam [5:0] S_FLOAT = 6'b001000;
   localparam [5:0] S_LOCK  = 6'b010000;
   localparam [5:0] S_RUN   = 6'b100000;

   localparam [15:0] SETUP_N  = SETUP_CYC;
   localparam [15:0] LOCK_N   = LOCK_CYC;
   localparam [15:0] RTC_N    = RTC_HALF;
   localparam [3:0]  SETUP_T  = `RICS_CFG_SETUP_TICKS;
   localparam [3:0]  HOLD_T   = `RICS_CFG_HOLD_TICKS;
   localparam [3:0]  FLOAT_T  = `RICS_CFG_FLOAT_TICKS;
   localparam [1:0]  SOFT_T   = `RICS_SOFT_TICKS;

   // ==================================================
   // soft reset counter step, shared by both cores
   function [1:0] soft_step;
      input [1:0] cnt;
      input       tick;
      begin
         if (cnt != 2'b00 && tick)
            soft_step = cnt - 2'b01;
         else
            soft_step = cnt;
      end
   endfunction

   // ==================================================
   // primary clock generation
   wire pclk_tick;

   rics_clkdiv #(
      .HALF      (PCLK_HALF)
   ) u_clkdiv (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .clk_out   (primary_input_clock),
      .rise_tick (pclk_tick)
   );

   // ==================================================
   // power_good synchroniser
   reg pg_meta_r;
   reg pg_sync_r;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pg_meta_r <= 1'b0;
         pg_sync_r <= 1'b0;
      end else begin
         pg_meta_r <= power_good;
         pg_sync_r <= pg_meta_r;
      end
   end

   // ==================================================
   // platform frequency checks
   reg        strap_calc;
   reg        pcie_ok;
   reg        srio_ok;
   reg [31:0] pcie_lhs;
   reg [31:0] pcie_rhs;
   reg [31:0] srio_lhs;
   reg [31:0] srio_rhs;

   always @* begin
      // strap 1 only above the base rate
      strap_calc = (cfg_plat_mhz > 12'd`RICS_PLAT_BASE_MHZ);
      // mhz * (1 + strap) * 16 >= 527 * lanes
      pcie_lhs = {20'h0_0000, cfg_plat_mhz} * (strap_calc ? 32'h0000_0002
                 : 32'h0000_0001) * `RICS_PCIE_FULL_LANES;
      pcie_rhs = `RICS_PCIE_FLOOR_MHZ * {27'h000_0000, cfg_pcie_lanes};
      pcie_ok  = !cfg_pcie_en || (pcie_lhs >= pcie_rhs);
      // mhz * 10000 >= 2 * 8512 * rate * lanes
      srio_lhs = {20'h0_0000, cfg_plat_mhz} * `RICS_SRIO_SCALE;
      srio_rhs = `RICS_SRIO_FACTOR * {20'h0_0000, cfg_srio_mhz}
                 * {29'h0000_0000, cfg_srio_lanes};
      srio_ok  = !cfg_srio_en || (srio_lhs >= srio_rhs);
   end

   // ==================================================
   // main sequence
   reg [5:0]  state_r;
   reg [15:0] cyc_r;
   reg [3:0]  tick_r;
   reg [1:0]  soft0_r;
   reg [1:0]  soft1_r;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r            <= S_OFF;
         cyc_r              <= 16'h0000;
         tick_r             <= 4'h0;
         hard_reset_n       <= 1'b0;
         strap_out          <= {STRAP_W{1'b0}};
         plat_freq_strap    <= 1'b0;
         strap_oe_n         <= 1'b1;
         seq_ready          <= 1'b0;
         cfg_error          <= 1'b0;
      end else begin
         cfg_error <= !(pcie_ok && srio_ok);
         if (!pg_sync_r) begin
            // power lost: back to reset, straps float
            state_r      <= S_OFF;
            hard_reset_n <= 1'b0;
            strap_oe_n   <= 1'b1;
            seq_ready    <= 1'b0;
            cyc_r        <= 16'h0000;
            tick_r       <= 4'h0;
         end else begin
            case (state_r)
               S_OFF: begin
                  if (pcie_ok && srio_ok) begin
                     // latch and drive all straps while clock runs
                     strap_out       <= cfg_straps;
                     plat_freq_strap <= strap_calc;
                     strap_oe_n      <= 1'b0;
                     state_r         <= S_SETUP;
                  end
               end
               S_SETUP: begin
                  // hard reset low, clock and straps stable
                  if (cyc_r != SETUP_N)
                     cyc_r <= cyc_r + 16'h0001;
                  if (pclk_tick && tick_r != SETUP_T)
                     tick_r <= tick_r + 4'h1;
                  if (cyc_r == SETUP_N && tick_r == SETUP_T
                      && pclk_tick) begin
                     hard_reset_n <= 1'b1;
                     tick_r       <= 4'h0;
                     cyc_r        <= 16'h0000;
                     state_r      <= S_HOLD;
                  end
               end
               S_HOLD: begin
                  // straps unchanged past the negation edge
                  if (pclk_tick)
                     tick_r <= tick_r + 4'h1;
                  if (pclk_tick && tick_r == HOLD_T)
                     state_r <= S_FLOAT;
               end
               S_FLOAT: begin
                  if (pclk_tick)
                     tick_r <= tick_r + 4'h1;
                  if (pclk_tick && tick_r == FLOAT_T) begin
                     strap_oe_n <= 1'b1;
                     state_r    <= S_LOCK;
                  end
               end
               S_LOCK: begin
                  // wait longest lock time plus core extra cycles
                  cyc_r <= cyc_r + 16'h0001;
                  if (cyc_r == LOCK_N - 16'h0001) begin
                     seq_ready <= 1'b1;
                     state_r   <= S_RUN;
                  end
               end
               S_RUN: begin
                  seq_ready <= 1'b1;
               end
               default: begin
                  state_r <= S_OFF;
               end
            endcase
         end
      end
   end

   // ==================================================
   // core soft resets, only while running; ticks count once the pin is low
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         soft0_r            <= 2'b00;
         soft1_r            <= 2'b00;
         core0_soft_reset_n <= 1'b1;
         core1_soft_reset_n <= 1'b1;
         soft_busy          <= 1'b0;
      end else begin
         if (core0_soft_req && soft0_r == 2'b00 && state_r == S_RUN)
            soft0_r <= SOFT_T;
         else
            soft0_r <= soft_step(soft0_r,
                                 pclk_tick & ~core0_soft_reset_n);
         if (core1_soft_req && soft1_r == 2'b00 && state_r == S_RUN)
            soft1_r <= SOFT_T;
         else
            soft1_r <= soft_step(soft1_r,
                                 pclk_tick & ~core1_soft_reset_n);
         core0_soft_reset_n <= (soft0_r == 2'b00);
         core1_soft_reset_n <= (soft1_r == 2'b00);
         soft_busy          <= (soft0_r != 2'b00) || (soft1_r != 2'b00);
      end
   end

   // ==================================================
   // real-time clock source, grounded when disabled
   reg [15:0] rtc_cnt_r;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rtc_cnt_r <= 16'h0000;
         rtc_out   <= 1'b0;
      end else if (!rtc_enable) begin
         rtc_cnt_r <= 16'h0000;
         rtc_out   <= 1'b0;
      end else if (rtc_cnt_r == RTC_N - 16'h0001) begin
         rtc_cnt_r <= 16'h0000;
         rtc_out   <= ~rtc_out;
      end else begin
         rtc_cnt_r <= rtc_cnt_r + 16'h0001;
      end
   end

endmodule

// >>> test/rics_checker.sv
`timescale 1ns/1ps
// ==========
// pin checker for the reset sequencer
module rics_checker #(
   parameter STRAP_W   = 8,
   parameter SETUP_CYC = 20
) (
   // clock and reset
   input logic               clk_sys,
   input logic               reset_n,
   // user configuration
   input logic [STRAP_W-1:0] cfg_straps,
   input logic [11:0]        cfg_plat_mhz,
   // device pins and status
   input logic               primary_input_clock,
   input logic               hard_reset_n,
   input logic               core0_soft_reset_n,
   input logic [STRAP_W-1:0] strap_out,
   input logic               plat_freq_strap,
   input logic               strap_oe_n,
   input logic               rtc_out,
   input logic               seq_ready,
   input logic               cfg_error
);
   logic        pclk_d_r;
   logic [15:0] lo_cyc_r;
   logic [15:0] drv_cyc_r;
   logic [7:0]  drv_tk_r;
   logic [7:0]  soft_tk_r;
   wire         tick = primary_input_clock & ~pclk_d_r;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // time counters for reset low, straps driven and soft low
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pclk_d_r  <= 1'b0;
         lo_cyc_r  <= 16'h0000;
         drv_cyc_r <= 16'h0000;
         drv_tk_r  <= 8'h00;
         soft_tk_r <= 8'h00;
      end else begin
         pclk_d_r  <= primary_input_clock;
         lo_cyc_r  <= hard_reset_n ? 16'h0000 : lo_cyc_r + 16'h0001;
         drv_cyc_r <= strap_oe_n ? 16'h0000 : drv_cyc_r + 16'h0001;
         drv_tk_r  <= strap_oe_n ? 8'h00 : drv_tk_r + {7'h00, tick};
         soft_tk_r <= core0_soft_reset_n ? 8'h00 : soft_tk_r + {7'h00, tick};
      end
   end

   hard_reset_n_len_a: assert property ($rose(hard_reset_n) |->
      lo_cyc_r >= SETUP_CYC) else $error("hard reset too short");
   pll_setup_a: assert property ($rose(hard_reset_n) |->
      drv_cyc_r >= SETUP_CYC) else $error("pll setup too short");
   cfg_setup_a: assert property ($rose(hard_reset_n) |->
      drv_tk_r >= 8'h04) else $error("strap setup too short");
   cfg_hold_a: assert property ($rose(hard_reset_n) |=>
      (!strap_oe_n && $stable(strap_out) && $stable(plat_freq_strap))[*4])
      else $error("strap hold too short");
   float_max_a: assert property ($rose(hard_reset_n) |->
      ##[4:10] strap_oe_n) else $error("straps not released");
   soft_len_a: assert property ($rose(core0_soft_reset_n) |->
      soft_tk_r >= 8'h03) else $error("soft reset too short");
   freq_strap_a: assert property ($fell(strap_oe_n) |->
      plat_freq_strap == ($past(cfg_plat_mhz) > 12'h190))
      else $error("frequency strap wrong");
   strap_copy_a: assert property ($fell(strap_oe_n) |->
      strap_out == $past(cfg_straps)) else $error("strap value wrong");
   cfg_block_a: assert property (cfg_error |->
      !hard_reset_n && strap_oe_n) else $error("bad config released");
   ready_wait_a: assert property ($rose(strap_oe_n) && hard_reset_n |->
      !seq_ready[*8] ##[1:4] seq_ready) else $error("ready timing wrong");
   rtc_phase_a: assert property ($changed(rtc_out) |=>
      $stable(rtc_out)[*2]) else $error("rtc phase too short");

   cover property ($rose(seq_ready));
   cover property ($rose(cfg_error));
   cover property ($rose(core0_soft_reset_n));
endmodule

bind rics_sequencer rics_checker #(
   .STRAP_W(STRAP_W),
   .SETUP_CYC(SETUP_CYC)
) i_rics_checker (
   .clk_sys, .reset_n, .cfg_straps, .cfg_plat_mhz, .primary_input_clock,
   .hard_reset_n, .core0_soft_reset_n, .strap_out, .plat_freq_strap,
   .strap_oe_n, .rtc_out, .seq_ready, .cfg_error
);

// >>> test/rics_dev_model.sv
`timescale 1ns/1ps
// ==========
// device seen through its reset and strap pins
module rics_dev_model #(
   parameter STRAP_W  = 8,
   parameter LOCK_CYC = 10
) (
   // platform clock stand-in
   input  wire               clk_sys,
   // reset and strap pins
   input  wire               primary_input_clock,
   input  wire               hard_reset_n,
   input  wire [STRAP_W-1:0] strap_out,
   input  wire               plat_freq_strap,
   input  wire               strap_oe_n,
   input  wire               rtc_out,
   // observed state
   output reg  [STRAP_W:0]   dev_straps,
   output reg                hold_bad,
   output reg                dev_ready,
   output reg                rtc_q
);
   reg  [STRAP_W:0] last_r;
   reg              pclk_d_r;
   reg  [1:0]       tk_r;
   reg  [15:0]      lock_r;
   wire             tick = primary_input_clock & ~pclk_d_r;
   // released pins show the inverse of the last driven value
   wire [STRAP_W:0] pins = strap_oe_n ? ~last_r
                                      : {plat_freq_strap, strap_out};

   // strap capture, lock wait and rtc latch
   always @(posedge clk_sys) begin
      pclk_d_r <= primary_input_clock;
      rtc_q    <= rtc_out;
      if (!strap_oe_n)
         last_r <= {plat_freq_strap, strap_out};
      if (!hard_reset_n) begin
         tk_r      <= 2'h0;
         lock_r    <= 16'h0000;
         dev_ready <= 1'b0;
         hold_bad  <= 1'b0;
      end else begin
         if (tick && tk_r != 2'h3) begin
            tk_r <= tk_r + 2'h1;
            if (tk_r == 2'h0)
               dev_straps <= pins;
            else if (pins !== dev_straps)
               hold_bad <= 1'b1;
         end
         if (lock_r < LOCK_CYC)
            lock_r <= lock_r + 16'h0001;
         else
            dev_ready <= 1'b1;
      end
   end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
// ==========
// sequencer bench with device model
module testbench;
   localparam SW = 8;
   reg clk_sys = 1'b0, reset_n = 1'b0, power_good = 1'b0, rtc_enable = 1'b0;
   reg [SW-1:0] cfg_straps = 8'h00;
   reg [11:0]   cfg_plat_mhz = 12'h190, cfg_srio_mhz = 12'h000;
   reg [4:0]    cfg_pcie_lanes = 5'h01;
   reg [2:0]    cfg_srio_lanes = 3'h1;
   reg cfg_pcie_en = 1'b0, cfg_srio_en = 1'b0;
   reg core0_soft_req = 1'b0, core1_soft_req = 1'b0;
   wire primary_input_clock, hard_reset_n, core0_soft_reset_n;
   wire core1_soft_reset_n, plat_freq_strap, strap_oe_n, rtc_out;
   wire seq_ready, cfg_error, soft_busy, hold_bad, dev_ready, rtc_q;
   wire [SW-1:0] strap_out;
   wire [SW:0]   dev_straps;
   integer mismatches = 0, checks = 0, cyc = 0, i, n, tog;
   integer seed = 32'hb7ea_fa49;
   reg prev;

   rics_sequencer #(.SETUP_CYC(20), .LOCK_CYC(10)) i_rics_sequencer (
      .clk_sys, .reset_n, .power_good, .cfg_straps, .cfg_plat_mhz,
      .cfg_pcie_en, .cfg_pcie_lanes, .cfg_srio_en, .cfg_srio_mhz,
      .cfg_srio_lanes, .rtc_enable, .core0_soft_req, .core1_soft_req,
      .primary_input_clock, .hard_reset_n, .core0_soft_reset_n,
      .core1_soft_reset_n, .strap_out, .plat_freq_strap, .strap_oe_n,
      .rtc_out, .seq_ready, .cfg_error, .soft_busy);
   rics_dev_model #(.STRAP_W(SW), .LOCK_CYC(10)) i_rics_dev_model (
      .clk_sys, .primary_input_clock, .hard_reset_n, .strap_out,
      .plat_freq_strap, .strap_oe_n, .rtc_out, .dev_straps, .hold_bad,
      .dev_ready, .rtc_q);

   // clock and hang limit
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         results;
      end
   end

   task results;
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task clocks(input integer k);
      repeat (k) @(negedge clk_sys);
   endtask

   task chk(input [SW:0] got, input [SW:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   // floors for the frequency checks
   function exp_err(input [11:0] m, input pe, input [4:0] pl, input se,
                    input [11:0] sm, input [2:0] sl);
      exp_err = (pe && m * ((m > 12'h190) + 1) * 16'h0010 < 16'h020f * pl)
             || (se && m * 32'h0000_2710 < 32'h0000_4280 * sm * sl);
   endfunction

   // one power-up with a given configuration
   task run_cfg(input [11:0] m, input pe, input [4:0] pl, input se,
                input [11:0] sm, input [2:0] sl, input [SW-1:0] st);
      reg err;
      begin
         err = exp_err(m, pe, pl, se, sm, sl);
         power_good = 1'b0;
         clocks(4);
         {cfg_plat_mhz, cfg_pcie_en, cfg_pcie_lanes} = {m, pe, pl};
         {cfg_srio_en, cfg_srio_mhz, cfg_srio_lanes} = {se, sm, sl};
         cfg_straps = st;
         power_good = 1'b1;
         for (n = 0; n < 200 && seq_ready !== 1'b1; n = n + 1)
            clocks(1);
         chk(cfg_error, err);
         chk(seq_ready, !err);
         if (!err) begin
            chk(dev_straps, {m > 12'h190, st});
            chk(hold_bad, 1'b0);
            chk(dev_ready, 1'b1);
         end else
            chk(hard_reset_n, 1'b0);
      end
   endtask

   initial begin
      clocks(2);
      reset_n = 1'b1;
      for (i = 0; i < 6; i = i + 1)
         run_cfg(($random(seed) & 12'h1ff) + 12'h12c, $random(seed),
                 5'h01 << ($random(seed) & 3), $random(seed),
                 $random(seed) & 12'h0ff, ($random(seed) & 3) + 1,
                 $random(seed));
      run_cfg(12'h190, 1'b1, 5'h10, 1'b0, 12'h000, 3'h1, 8'h5a);
      run_cfg(12'h190, 1'b0, 5'h01, 1'b1, 12'h0eb, 3'h1, 8'h3c);
      run_cfg(12'h190, 1'b1, 5'h08, 1'b1, 12'h075, 3'h2, 8'ha5);
      run_cfg(12'h20f, 1'b1, 5'h08, 1'b0, 12'h000, 3'h1, 8'hff);
      // both soft resets, then a request while busy
      core0_soft_req = 1'b1;
      core1_soft_req = 1'b1;
      clocks(1);
      {core0_soft_req, core1_soft_req} = 2'b00;
      clocks(2);
      chk({soft_busy, core0_soft_reset_n, core1_soft_reset_n}, 3'h4);
      core0_soft_req = 1'b1;
      clocks(1);
      core0_soft_req = 1'b0;
      for (n = 0; n < 40 && soft_busy !== 1'b0; n = n + 1)
         clocks(1);
      clocks(3);
      chk({soft_busy, core0_soft_reset_n, core1_soft_reset_n}, 3'h3);
      // rtc held low, then running
      for (i = 0; i < 8; i = i + 1) begin
         clocks(3);
         chk(rtc_q, 1'b0);
      end
      rtc_enable = 1'b1;
      clocks(2);
      tog = 0;
      prev = rtc_q;
      for (i = 0; i < 40; i = i + 1) begin
         clocks(1);
         if (rtc_q !== prev)
            tog = tog + 1;
         prev = rtc_q;
      end
      chk(tog >= 9 && tog <= 11, 1'b1);
      power_good = 1'b0;
      clocks(5);
      chk({hard_reset_n, seq_ready}, 2'h0);
      results;
   end
endmodule
